// File: design/watchdog_pkg.sv
/*
 * constants and types for the i/o port watchdog timer.
 * assumes one 125 mhz core clock and a host i/o read decoder upstream.
 */
// Notes on behaviour
// - a host read of the enable port arms the watchdog and starts counting
// - a host read of the disable port disarms it and blocks any timeout action
// - on expiry assert system reset or nmi per action select; settings 0 and 3 disable
// - six static periods: 1, 2, 10, 20, 110 and 220 seconds
package watchdog_pkg;

    // ------------------------------------------------------------
    // port addresses and timing
    // ------------------------------------------------------------
    localparam logic [15:0] ENABLE_PORT_ADDR  = 16'h0443;
    localparam logic [15:0] DISABLE_PORT_ADDR = 16'h0043;
    localparam int          CLK_FREQ_HZ       = 125_000_000;
    localparam int          TICK_PERIOD_S     = 1;
    localparam int          TICK_CYCLES       = CLK_FREQ_HZ * TICK_PERIOD_S;
    localparam int          PERIOD_S_1        = 1;
    localparam int          PERIOD_S_2        = 2;
    localparam int          PERIOD_S_10       = 10;
    localparam int          PERIOD_S_20       = 20;
    localparam int          PERIOD_S_110      = 110;
    localparam int          PERIOD_S_220      = 220;
    localparam int          SEC_W             = 8;
    localparam int          SEL_W             = 3;
    localparam int          PULSE_CYCLES      = 16;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ACT_DISABLED = 2'h0,
        ACT_RESET    = 2'h1,
        ACT_NMI      = 2'h2
    } action_t;

    typedef struct packed {
        logic        rd;
        logic [15:0] addr;
    } io_read_t;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_ARMED = 3'b010,
        ST_FIRE  = 3'b100
    } wd_state_t;

    function automatic logic [SEC_W-1:0] period_secs(input logic [SEL_W-1:0] sel);
        case (sel)
            3'h0:    period_secs = SEC_W'(PERIOD_S_1);
            3'h1:    period_secs = SEC_W'(PERIOD_S_2);
            3'h2:    period_secs = SEC_W'(PERIOD_S_10);
            3'h3:    period_secs = SEC_W'(PERIOD_S_20);
            3'h4:    period_secs = SEC_W'(PERIOD_S_110);
            default: period_secs = SEC_W'(PERIOD_S_220);
        endcase
    endfunction : period_secs

endpackage : watchdog_pkg

// File: design/io_port_watchdog.sv
/*
 * watchdog timer armed and disarmed by host i/o reads.
 * assumes io_rd is a one-cycle pulse on core_clk; selects are static pins.
 */
`timescale 1ns/1ps
module io_port_watchdog
    import watchdog_pkg::*;
#(
    parameter int TICK_CYCLES_P = TICK_CYCLES
) (
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             srst,
    // host i/o read
    input  wire io_read_t         io_req,
    // static selects (pins)
    input  wire logic [SEL_W-1:0] timeout_period_select,
    input  wire logic [1:0]       expiry_action_select,
    // outputs
    output logic                  sys_reset_q,
    output logic                  nmi_q,
    output logic                  armed_q
);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [SEL_W-1:0] per_s1_q, per_s2_q;
    logic [1:0]       act_s1_q, act_s2_q;
    always_ff @(posedge core_clk) begin
        per_s1_q <= timeout_period_select;
        per_s2_q <= per_s1_q;
        act_s1_q <= expiry_action_select;
        act_s2_q <= act_s1_q;
    end

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    wire act_off  = (action_t'(act_s2_q) != ACT_RESET) && (action_t'(act_s2_q) != ACT_NMI);
    wire rd_en    = io_req.rd && (io_req.addr == ENABLE_PORT_ADDR);
    wire rd_dis   = io_req.rd && (io_req.addr == DISABLE_PORT_ADDR);
    wire [SEC_W-1:0] limit = period_secs(per_s2_q);

    wd_state_t      state_q, state_d;
    logic [31:0]    pre_q;
    logic [SEC_W-1:0] sec_q;
    logic [4:0]     pulse_q;

    wire tick    = (pre_q == 32'(TICK_CYCLES_P - 1));
    wire expire  = (state_q == ST_ARMED) && tick && (sec_q + 1'b1 >= limit);

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE:  if (rd_en && !act_off) state_d = ST_ARMED;
            ST_ARMED: begin
                if (rd_dis || act_off) state_d = ST_IDLE;
                else if (rd_en)        state_d = ST_ARMED;
                else if (expire)       state_d = ST_FIRE;
            end
            ST_FIRE:  if (pulse_q == 5'(PULSE_CYCLES - 1)) state_d = ST_IDLE;
            default:  state_d = ST_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // counters and outputs
    // ------------------------------------------------------------
    wire restart = (state_q != ST_ARMED) || rd_en;
    always_ff @(posedge core_clk) begin
        if (srst) begin
            state_q <= ST_IDLE;
            pre_q   <= 32'h0;
            sec_q   <= '0;
            pulse_q <= 5'h0;
        end else begin
            state_q <= state_d;
            pre_q   <= (restart || tick) ? 32'h0 : pre_q + 32'h1;
            sec_q   <= restart ? '0 : (tick ? sec_q + 1'b1 : sec_q);
            pulse_q <= (state_q == ST_FIRE) ? pulse_q + 5'h1 : 5'h0;
        end
    end

    logic fire_rst, fire_nmi;
    assign fire_rst = (state_d == ST_FIRE) && (action_t'(act_s2_q) == ACT_RESET);
    assign fire_nmi = (state_d == ST_FIRE) && (action_t'(act_s2_q) == ACT_NMI);
    always_ff @(posedge core_clk) begin
        if (srst) begin
            sys_reset_q <= 1'b0;
            nmi_q       <= 1'b0;
            armed_q     <= 1'b0;
        end else begin
            sys_reset_q <= fire_rst;
            nmi_q       <= fire_nmi;
            armed_q     <= (state_d == ST_ARMED);
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    a_enable_arms: assert property (
        (state_q == ST_IDLE) && rd_en && !act_off |=> armed_q)
        else $error("enable read did not arm");
    a_disable_disarms: assert property (
        (state_q == ST_ARMED) && rd_dis |=> !armed_q ##1 !sys_reset_q && !nmi_q)
        else $error("disable read did not disarm");
    a_off_no_action: assert property (
        act_off && $stable(act_s2_q) |=> !sys_reset_q && !nmi_q)
        else $error("action while select disables");
    a_kick_restarts: assert property (
        (state_q == ST_ARMED) && rd_en && !rd_dis && !act_off |=> sec_q == '0 && pre_q == 32'h0)
        else $error("retrigger did not restart count");
    a_expire_fires: assert property (
        expire && !rd_en && !rd_dis && !act_off |=> (sys_reset_q || nmi_q))
        else $error("expiry produced no action");
    a_period_bound: assert property (
        (state_q == ST_ARMED) |-> sec_q < limit || !$stable(per_s2_q))
        else $error("count passed selected period");
    a_reset_only: assert property (
        sys_reset_q |-> !nmi_q && $past(action_t'(act_s2_q) == ACT_RESET))
        else $error("reset fired with wrong select");
    a_pulse_len: assert property (
        $rose(nmi_q) |-> nmi_q [*8])
        else $error("nmi pulse too short");

    // ------------------------------------------------------------
    // named sequences
    // ------------------------------------------------------------
    sequence s_disable_taken;
        (state_q == ST_ARMED) && rd_dis;
    endsequence

    sequence s_expiry_taken;
        expire && !rd_en && !rd_dis && !act_off;
    endsequence

    sequence s_reset_pulse;
        sys_reset_q [*8] ##1 sys_reset_q [*8] ##1 !sys_reset_q;
    endsequence

    sequence s_nmi_pulse;
        nmi_q [*8] ##1 nmi_q [*8] ##1 !nmi_q;
    endsequence

    // ------------------------------------------------------------
    // assertions: arming
    // ------------------------------------------------------------
    a_armed_state: assert property (
        armed_q == (state_q == ST_ARMED))
        else $error("armed flag differs from state");

    a_arm_cause: assert property (
        $rose(armed_q) |-> $past(rd_en))
        else $error("armed without enable read");

    a_idle_stays: assert property (
        (state_q == ST_IDLE) && !rd_en |=> !armed_q)
        else $error("idle state armed by other read");

    a_disarm_cause: assert property (
        $fell(armed_q) && !$past(srst) |-> $past(rd_dis || act_off || expire))
        else $error("disarmed without cause");

    a_disable_idle: assert property (
        s_disable_taken |=> state_q == ST_IDLE)
        else $error("disable read left state active");

    // ------------------------------------------------------------
    // assertions: counting
    // ------------------------------------------------------------
    a_state_onehot: assert property (
        $onehot(state_q))
        else $error("state code not one-hot");

    a_count_cleared: assert property (
        (state_q != ST_ARMED) |=> sec_q == '0)
        else $error("seconds count not cleared");

    a_kick_armed: assert property (
        (state_q == ST_ARMED) && rd_en && !act_off |=> armed_q)
        else $error("retrigger dropped the armed state");

    a_prescale_range: assert property (
        pre_q < 32'(TICK_CYCLES_P))
        else $error("prescaler passed tick length");

    a_sec_hold: assert property (
        (state_q == ST_ARMED) && !rd_en && !tick |=> $stable(sec_q))
        else $error("seconds count moved without tick");

    // ------------------------------------------------------------
    // assertions: actions
    // ------------------------------------------------------------
    a_expiry_state: assert property (
        s_expiry_taken |=> state_q == ST_FIRE)
        else $error("expiry did not enter action state");

    a_action_not_armed: assert property (
        (sys_reset_q || nmi_q) |-> !armed_q)
        else $error("action while still armed");

    a_idle_quiet: assert property (
        (state_q == ST_IDLE) |-> !sys_reset_q && !nmi_q)
        else $error("action output high while idle");

    a_off_refuses: assert property (
        act_off |=> !armed_q)
        else $error("armed while select disables");

    a_nmi_only: assert property (
        nmi_q |-> !sys_reset_q && $past(action_t'(act_s2_q) == ACT_NMI))
        else $error("nmi fired with wrong select");

    a_reset_pulse_len: assert property (
        $rose(sys_reset_q) |-> s_reset_pulse)
        else $error("reset pulse length wrong");

    a_nmi_pulse_len: assert property (
        $rose(nmi_q) |-> s_nmi_pulse)
        else $error("nmi pulse length wrong");

endmodule : io_port_watchdog

// File: verif/host_io_model.sv
/* host cpu model issuing i/o port reads.
   assumes core_clk from the bench; callers enter just after a rising edge. */
`timescale 1ns/1ps
module host_io_model
    import watchdog_pkg::*;
(
    // clock
    input  wire logic core_clk,
    // host read
    output io_read_t  io_req
);
    initial io_req = '{rd: 1'b0, addr: 16'h0000};
    // one-cycle read, address released to its inverse
    task automatic rd(input logic [15:0] a);
        io_req = '{rd: 1'b1, addr: a};
        @(posedge core_clk);
        #1 io_req = '{rd: 1'b0, addr: ~a};
    endtask : rd
endmodule : host_io_model

// File: verif/io_port_watchdog_tb.sv
/* self-checking bench for the i/o port watchdog.
   assumes TICK_CYCLES_P of 10 cycles per second. */
`timescale 1ns/1ps
module io_port_watchdog_tb;
    import watchdog_pkg::*;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    localparam int TK = 10;
    logic       core_clk, srst, sys_reset_q, nmi_q, armed_q;
    logic [2:0] per;
    logic [1:0] act;
    io_read_t   io_req;
    int         n_fail, checks_done, cyc, n;
    int         ps[8] = '{1, 2, 10, 20, 110, 220, 220, 220};
    initial begin
        core_clk = 0;
        forever #4 core_clk = ~core_clk;
    end
    io_port_watchdog #(.TICK_CYCLES_P(TK)) i_dut (.core_clk(core_clk), .srst(srst),
        .io_req(io_req), .timeout_period_select(per), .expiry_action_select(act),
        .sys_reset_q(sys_reset_q), .nmi_q(nmi_q), .armed_q(armed_q));
    host_io_model i_host (.core_clk(core_clk), .io_req(io_req));
    task chk(input logic [15:0] s, input logic [15:0] e);
        checks_done++;
        if (s !== e) begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    task step(input int k);
        repeat (k) @(posedge core_clk);
        #1;
    endtask : step
    task fire();
        n = 0;
        while (sys_reset_q !== 1'b1 && nmi_q !== 1'b1 && n < 3000) begin
            step(1);
            n++;
        end
    endtask : fire
    task conclude();
        $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : conclude
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task t_periods();
        for (int s = 0; s < 8; s++) begin
            per = 3'(s);
            act = ACT_RESET;
            step(3);
            i_host.rd(ENABLE_PORT_ADDR);
            chk(armed_q, 1);
            fire();
            chk(n >= (ps[s] - 1) * TK && n <= ps[s] * TK + 3, 1);
            chk({sys_reset_q, nmi_q, armed_q}, 3'b100);
            step(15);
            chk(sys_reset_q, 1);
            step(1);
            chk(sys_reset_q, 0);
        end
    endtask : t_periods
    task t_nmi_retrig();
        per = 3'h1;
        act = ACT_NMI;
        step(3);
        i_host.rd(ENABLE_PORT_ADDR);
        repeat (6) begin
            step(7);
            i_host.rd(ENABLE_PORT_ADDR);
        end
        chk({nmi_q, armed_q}, 2'b01);
        fire();
        chk(n >= TK && n <= 2 * TK + 3, 1);
        chk({sys_reset_q, nmi_q}, 2'b01);
        step(17);
    endtask : t_nmi_retrig
    task t_disable_refuse();
        per = 3'h0;
        act = ACT_RESET;
        i_host.rd(ENABLE_PORT_ADDR);
        step(3);
        i_host.rd(DISABLE_PORT_ADDR);
        chk(armed_q, 0);
        step(40);
        chk(sys_reset_q, 0);
        i_host.rd(16'h0044);
        chk(armed_q, 0);
        act = ACT_DISABLED;
        step(3);
        i_host.rd(ENABLE_PORT_ADDR);
        chk(armed_q, 0);
        act = 2'h3;
        step(3);
        i_host.rd(ENABLE_PORT_ADDR);
        chk(armed_q, 0);
        act = ACT_RESET;
        step(3);
        i_host.rd(ENABLE_PORT_ADDR);
        chk(armed_q, 1);
        srst = 1;
        step(1);
        srst = 0;
        step(1);
        chk(armed_q, 0);
    endtask : t_disable_refuse
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            conclude();
        end
    end
    initial begin
        srst = 1;
        per = 3'h0;
        act = ACT_RESET;
        n_fail = 0;
        checks_done = 0;
        cyc = 0;
        step(10);
        srst = 0;
        chk({sys_reset_q, nmi_q, armed_q}, 3'b000);
        t_periods();
        t_nmi_retrig();
        t_disable_refuse();
        conclude();
    end
endmodule : io_port_watchdog_tb
